// *** common/fault_decide_if.sv ***
// Purpose: carrier between the gate and its fault decider
// Assumes: one clock domain
// Notes:   gate drives the inputs, decider the results
`timescale 1ns/1ps
`default_nettype none
interface fault_decide_if;
	logic fault;
	logic fx_en;
	logic me;
	logic rpt;
	logic ctrl_irq;
	logic mchk;
	logic cstop;
	logic stall;
	logic drop;
	modport gate (output fault, fx_en, me, rpt, ctrl_irq, input mchk, cstop, stall, drop);
	modport dec (input fault, fx_en, me, rpt, ctrl_irq, output mchk, cstop, stall, drop);
endinterface
`default_nettype wire

// *** common/fimc_pkg.sv ***
// Purpose: constants for the fault input machine check gate
// Assumes: 32-bit avalon-mm register bus, byte addresses
// Notes:   status bits are sticky, write one to clear
package fimc_pkg;
	localparam int unsigned RSP_W      = 32;
	localparam int unsigned BUS_W      = 32;
	localparam int unsigned ADDR_W     = 4;
	// register byte offsets
	localparam logic [3:0]  OFF_CTRL   = 4'h0;
	localparam logic [3:0]  OFF_STATUS = 4'h4;
	localparam logic [3:0]  OFF_MASK   = 4'h8;
	localparam logic [3:0]  OFF_STATE  = 4'hc;
	// control fields
	localparam int unsigned CTRL_FX_EN = 0;
	localparam int unsigned CTRL_ME    = 1;
	localparam int unsigned CTRL_RPT   = 2;
	localparam logic [2:0]  CTRL_RST   = 3'h0;
	// status and mask fields
	localparam int unsigned ST_FAULT   = 0;
	localparam int unsigned ST_MCHK    = 1;
	localparam int unsigned ST_CSTOP   = 2;
	localparam int unsigned ST_CIRQ    = 3;
	localparam int unsigned ST_STALL   = 4;
	localparam int unsigned ST_W       = 5;
	localparam logic [4:0]  STATUS_RST = 5'h00;
	localparam logic [4:0]  MASK_RST   = 5'h00;
	// state fields
	localparam int unsigned SS_STALL   = 0;
	localparam int unsigned SS_CSTOP   = 1;
	localparam int unsigned SS_BUSY    = 2;
	// bus answer timing, request edge to completion edge
	localparam int unsigned BUS_LAT    = 2;
endpackage

// *** design/fault_decide.sv ***
// Purpose: decides stall, machine check or checkstop on a fault
// Assumes: fault already qualified by a response
// Notes:   stall ends only on a reported controller interrupt
`timescale 1ns/1ps
`default_nettype none
module fault_decide (
	// clock and reset
	input wire logic    mclk,
	input wire logic    rst,
	// decision carrier
	fault_decide_if.dec fd
);
	typedef struct packed {
		logic stall;
		logic cstop;
	} dec_st_t;

	dec_st_t s_q;
	dec_st_t s_d;
	logic    irq_ok;

	assign irq_ok = fd.ctrl_irq & fd.rpt;

	always_comb begin
		s_d = s_q;
		if (fd.fault & ~fd.fx_en) begin
			s_d.stall = 1'b1;
		end else if (irq_ok) begin
			s_d.stall = 1'b0;
		end
		if (fd.fault & fd.fx_en & ~fd.me) begin
			s_d.cstop = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fd.mchk  = fd.fault & fd.fx_en & fd.me & ~s_q.cstop;
	assign fd.drop  = fd.fault | s_q.stall | s_q.cstop;
	assign fd.stall = s_q.stall;
	assign fd.cstop = s_q.cstop;

	a_dis_no_mchk: assert property (@(posedge mclk) disable iff (rst)
		(fd.fault && !fd.fx_en) |-> !fd.mchk)
		else $error("machine check raised with enable clear");
	a_en_no_stall: assert property (@(posedge mclk) disable iff (rst)
		(fd.fault && fd.fx_en && !s_q.stall && !fd.ctrl_irq) |=> !s_q.stall)
		else $error("stall entered with enable set");
endmodule // fault_decide
`default_nettype wire

// *** design/fault_input_machine_check_gate.sv ***
// Purpose: gate between fault reporting logic and core exceptions
// Assumes: responses and interrupts synchronous to mclk
// Notes:   registers over avalon-mm, two-cycle answer
`timescale 1ns/1ps
`default_nettype none
module fault_input_machine_check_gate #(
	parameter int unsigned RSP_W = fimc_pkg::RSP_W
) (
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         rst,
	// avalon-mm slave
	input  wire logic [fimc_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [fimc_pkg::BUS_W-1:0]   avs_writedata,
	input  wire logic [3:0]                   avs_byteenable,
	output logic [fimc_pkg::BUS_W-1:0]        avs_readdata,
	output logic                              avs_waitrequest,
	// responses from cache and bus bridges
	input  wire logic                         rsp_valid,
	input  wire logic                         rsp_instr,
	input  wire logic [RSP_W-1:0]             rsp_data,
	input  wire logic                         fault_in,
	// interrupt steering controller
	input  wire logic                         ctrl_irq_in,
	// to the core
	output logic                              use_valid,
	output logic                              use_instr,
	output logic [RSP_W-1:0]                  use_data,
	output logic                              stall,
	output logic                              machine_check,
	output logic                              checkstop,
	output logic                              irq
);
	typedef struct packed {
		logic                        waitreq;
		logic [fimc_pkg::BUS_W-1:0]  rdata;
		logic                        fx_en;
		logic                        me;
		logic                        rpt;
		logic [fimc_pkg::ST_W-1:0]   status;
		logic [fimc_pkg::ST_W-1:0]   mask;
		logic                        use_valid;
		logic                        use_instr;
		logic [RSP_W-1:0]            use_data;
		logic                        stall;
		logic                        mchk;
		logic                        cstop;
		logic                        irq;
	} gate_st_t;

	gate_st_t                  s_q;
	gate_st_t                  s_d;
	logic                      req;
	logic                      wr_go;
	logic                      fault;
	logic [fimc_pkg::ST_W-1:0] ev;
	logic [fimc_pkg::ST_W-1:0] clr;
	logic                      waitreq_seen;

	fault_decide_if fd ();

	fault_decide u_dec (
		.mclk (mclk),
		.rst  (rst),
		.fd   (fd)
	);

	function automatic logic hit(logic [fimc_pkg::ADDR_W-1:0] a, logic [3:0] off);
		return a == off;
	endfunction

	function automatic logic [fimc_pkg::BUS_W-1:0] rd_word(logic [fimc_pkg::ADDR_W-1:0] a,
							      gate_st_t st);
		logic [fimc_pkg::BUS_W-1:0] r;
		r = '0;
		if (hit(a, fimc_pkg::OFF_CTRL)) begin
			r[fimc_pkg::CTRL_FX_EN] = st.fx_en;
			r[fimc_pkg::CTRL_ME]    = st.me;
			r[fimc_pkg::CTRL_RPT]   = st.rpt;
		end else if (hit(a, fimc_pkg::OFF_STATUS)) begin
			r[fimc_pkg::ST_W-1:0] = st.status;
		end else if (hit(a, fimc_pkg::OFF_MASK)) begin
			r[fimc_pkg::ST_W-1:0] = st.mask;
		end else if (hit(a, fimc_pkg::OFF_STATE)) begin
			r[fimc_pkg::SS_STALL] = st.stall;
			r[fimc_pkg::SS_CSTOP] = st.cstop;
			r[fimc_pkg::SS_BUSY]  = st.stall | st.cstop;
		end
		return r;
	endfunction

	// fault sources: cache ecc, bridge abort, any failed delivery
	assign fault       = rsp_valid & fault_in;
	assign fd.fault    = fault;
	assign fd.fx_en    = s_q.fx_en;
	assign fd.me       = s_q.me;
	assign fd.rpt      = s_q.rpt;
	assign fd.ctrl_irq = ctrl_irq_in;

	assign req   = avs_read | avs_write;
	assign wr_go = avs_write & ~s_q.waitreq & avs_byteenable[0];

	always_comb begin
		s_d = s_q;
		// bus: answer one cycle after the request is seen
		s_d.waitreq = 1'b1;
		if (req & s_q.waitreq) begin
			s_d.waitreq = 1'b0;
			s_d.rdata   = avs_read ? rd_word(avs_address, s_q) : '0;
		end
		if (wr_go & hit(avs_address, fimc_pkg::OFF_CTRL)) begin
			s_d.fx_en = avs_writedata[fimc_pkg::CTRL_FX_EN];
			s_d.me    = avs_writedata[fimc_pkg::CTRL_ME];
			s_d.rpt   = avs_writedata[fimc_pkg::CTRL_RPT];
		end
		if (wr_go & hit(avs_address, fimc_pkg::OFF_MASK)) begin
			s_d.mask = avs_writedata[fimc_pkg::ST_W-1:0];
		end
		// events, both interrupt sources kept apart
		ev                     = '0;
		ev[fimc_pkg::ST_FAULT] = fault;
		ev[fimc_pkg::ST_MCHK]  = fd.mchk;
		ev[fimc_pkg::ST_CSTOP] = fault & s_q.fx_en & ~s_q.me & ~fd.cstop;
		ev[fimc_pkg::ST_CIRQ]  = ctrl_irq_in;
		ev[fimc_pkg::ST_STALL] = fault & ~s_q.fx_en & ~fd.stall;
		clr = '0;
		if (wr_go & hit(avs_address, fimc_pkg::OFF_STATUS)) begin
			clr = avs_writedata[fimc_pkg::ST_W-1:0];
		end
		// set wins over clear
		s_d.status = (s_q.status & ~clr) | ev;
		s_d.irq    = |(s_d.status & s_d.mask);
		// data path: flagged or stalled data never reaches the core
		s_d.use_valid = rsp_valid & ~fd.drop;
		s_d.use_instr = rsp_instr;
		s_d.use_data  = fd.drop ? '0 : rsp_data;
		s_d.stall     = fd.stall;
		s_d.mchk      = fd.mchk;
		s_d.cstop     = fd.cstop;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q         <= '0;
			s_q.waitreq <= 1'b1;
			s_q.fx_en   <= fimc_pkg::CTRL_RST[fimc_pkg::CTRL_FX_EN];
			s_q.me      <= fimc_pkg::CTRL_RST[fimc_pkg::CTRL_ME];
			s_q.rpt     <= fimc_pkg::CTRL_RST[fimc_pkg::CTRL_RPT];
			s_q.status  <= fimc_pkg::STATUS_RST;
			s_q.mask    <= fimc_pkg::MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	assign use_valid       = s_q.use_valid;
	assign use_instr       = s_q.use_instr;
	assign use_data        = s_q.use_data;
	assign stall           = s_q.stall;
	assign machine_check   = s_q.mchk;
	assign checkstop       = s_q.cstop;
	assign irq             = s_q.irq;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence sq_off_fault;
		fault && !s_q.fx_en;
	endsequence
	sequence sq_on_fault_me;
		fault && s_q.fx_en && s_q.me && !fd.cstop;
	endsequence
	sequence sq_on_fault_cs;
		fault && s_q.fx_en && !s_q.me;
	endsequence
	sequence sq_on_fault;
		fault && s_q.fx_en;
	endsequence
	sequence sq_irq_rpt;
		ctrl_irq_in && s_q.rpt;
	endsequence
	sequence sq_bus_done;
		(avs_read || avs_write) && !s_q.waitreq;
	endsequence
	sequence sq_mask_wr;
		avs_write && !s_q.waitreq && avs_byteenable[0] && hit(avs_address, fimc_pkg::OFF_MASK);
	endsequence
	sequence sq_ctrl_wr;
		avs_write && !s_q.waitreq && avs_byteenable[0] && hit(avs_address, fimc_pkg::OFF_CTRL);
	endsequence
	sequence sq_rd_unmapped;
		avs_read && s_q.waitreq && (avs_address[1:0] != 2'h0);
	endsequence

	a_no_use_fault: assert property (fault |=> !use_valid)
		else $error("faulty data passed to core");
	a_off_stalls: assert property (sq_off_fault |=> ##1 stall)
		else $error("no stall after fault with enable clear");
	a_off_no_mchk: assert property (sq_off_fault |=> !machine_check)
		else $error("machine check with enable clear");
	a_on_mchk: assert property (sq_on_fault_me |=> machine_check)
		else $error("missing machine check");
	a_on_cstop: assert property (sq_on_fault_cs |=> ##1 checkstop)
		else $error("missing checkstop");
	a_stall_cause: assert property ($rose(stall) |-> $past(fault && !s_q.fx_en, 2))
		else $error("stall without a disabled fault");
	a_hold_until_irq: assert property ($fell(stall) |-> $past(ctrl_irq_in && s_q.rpt, 2))
		else $error("stall left without controller interrupt");
	a_both_irqs: assert property ((fd.mchk && ctrl_irq_in) |=>
		(s_q.status[fimc_pkg::ST_MCHK] && s_q.status[fimc_pkg::ST_CIRQ]))
		else $error("one of two interrupts lost");
	a_bus_answer: assert property ((req && waitreq_seen) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
	a_irq_level: assert property (irq |-> $past(|(s_d.status & s_d.mask)))
		else $error("interrupt without unmasked status");

	// fault path checks
	a_on_exception: assert property (
		sq_on_fault |=> (machine_check or (1'b1 ##1 checkstop)))
		else $error("enabled fault took no exception path");
	a_on_no_stall: assert property (
		(fault && s_q.fx_en && !fd.stall) |=> ##1 !stall)
		else $error("enabled fault stalled the core");
	a_mchk_cause: assert property (
		machine_check |-> $past(fault && s_q.fx_en && s_q.me))
		else $error("machine check without enabled fault");
	a_cstop_sticky: assert property (
		checkstop |=> checkstop)
		else $error("checkstop left before reset");
	a_cstop_no_mchk: assert property (
		checkstop |-> !machine_check)
		else $error("machine check during checkstop");
	a_fault_wins: assert property (
		(fault && !s_q.fx_en && ctrl_irq_in) |=> fd.stall)
		else $error("controller interrupt beat a disabled fault");
	a_stall_holds: assert property (
		(fd.stall && !(ctrl_irq_in && s_q.rpt)) |=> fd.stall)
		else $error("stall left without reported interrupt");
	a_irq_ends_stall: assert property (
		(sq_irq_rpt ##0 !(fault && !s_q.fx_en)) |=> !fd.stall)
		else $error("reported interrupt did not end stall");

	// data path checks
	a_stall_drops: assert property (
		(rsp_valid && fd.stall) |=> !use_valid)
		else $error("data used while stalled");
	a_cstop_drops: assert property (
		(rsp_valid && fd.cstop) |=> !use_valid)
		else $error("data used during checkstop");
	a_drop_zero: assert property (
		fd.drop |=> (use_data == '0))
		else $error("dropped data reached the core");
	a_clean_pass: assert property (
		(rsp_valid && !fd.drop) |=> (use_valid && use_data == $past(rsp_data)))
		else $error("clean data not handed over");

	// status and bus checks
	a_fault_sets: assert property (
		fault |=> s_q.status[fimc_pkg::ST_FAULT])
		else $error("fault not recorded");
	a_cirq_sets: assert property (
		ctrl_irq_in |=> s_q.status[fimc_pkg::ST_CIRQ])
		else $error("controller interrupt not recorded");
	a_mchk_sets: assert property (
		machine_check |-> s_q.status[fimc_pkg::ST_MCHK])
		else $error("machine check not recorded");
	a_status_sticky: assert property (
		!(wr_go && hit(avs_address, fimc_pkg::OFF_STATUS)) |=>
		((s_q.status & $past(s_q.status)) == $past(s_q.status)))
		else $error("status bit lost without a clear");
	a_idle_wait: assert property (
		!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("waitrequest low while idle");
	a_done_rises: assert property (
		sq_bus_done |=> avs_waitrequest)
		else $error("waitrequest low past completion");
	a_rd_unmapped: assert property (
		sq_rd_unmapped |=> (avs_readdata == '0))
		else $error("unmapped read not zero");
	a_mask_write: assert property (
		sq_mask_wr |=> (s_q.mask == $past(avs_writedata[fimc_pkg::ST_W-1:0])))
		else $error("mask write lost");
	a_ctrl_write: assert property (
		sq_ctrl_wr |=> (s_q.fx_en == $past(avs_writedata[fimc_pkg::CTRL_FX_EN]) &&
		s_q.me == $past(avs_writedata[fimc_pkg::CTRL_ME])))
		else $error("control write lost");
	a_be_ignored: assert property (
		(avs_write && !avs_byteenable[0]) |=> ($stable(s_q.mask) && $stable(s_q.fx_en)))
		else $error("write without byte zero took effect");

	assign waitreq_seen = s_q.waitreq;
endmodule // fault_input_machine_check_gate
`default_nettype wire

// *** verif/fault_source.sv ***
// Purpose: cache and bridge side reporting responses
// Assumes: called from bench tasks at rising edges
// Notes:   released lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module fault_source (
	// clock
	input  wire logic   mclk,
	// responses and controller interrupt
	output logic        rsp_valid,
	output logic        rsp_instr,
	output logic [31:0] rsp_data,
	output logic        fault_in,
	output logic        ctrl_irq_in
);
	initial {rsp_valid, rsp_instr, rsp_data, fault_in, ctrl_irq_in} = '0;
	task automatic send(input logic f, input logic i, input logic [31:0] d);
		{rsp_valid, rsp_instr, rsp_data, fault_in} <= {1'b1, i, d, f};
		@(posedge mclk);
		{rsp_valid, rsp_instr, rsp_data, fault_in} <= {1'b0, ~i, ~d, ~f};
	endtask
	task automatic pulse();
		ctrl_irq_in <= 1'b1;
		@(posedge mclk);
		ctrl_irq_in <= 1'b0;
	endtask
endmodule // fault_source
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the fault gate
// Assumes: fault_source stands for the response side
// Notes:   int model compared at every result
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        mclk, rst, avs_read, avs_write, avs_waitrequest, irq, stall;
	logic        rsp_valid, rsp_instr, fault_in, ctrl_irq_in, use_valid, use_instr;
	logic        machine_check, checkstop;
	logic [3:0]  avs_address, be;
	logic [31:0] avs_writedata, avs_readdata, rsp_data, use_data, rd;
	int          bad_count, comparisons, fx, me, rpt, st, mk, stl, cs;
	always #2.5 mclk = ~mclk;
	fault_input_machine_check_gate u_fault_input_machine_check_gate (.mclk, .rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(be),
		.avs_readdata, .avs_waitrequest, .rsp_valid, .rsp_instr, .rsp_data, .fault_in,
		.ctrl_irq_in, .use_valid, .use_instr, .use_data, .stall, .machine_check,
		.checkstop, .irq);
	fault_source u_far (.mclk, .rsp_valid, .rsp_instr, .rsp_data, .fault_in, .ctrl_irq_in);
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic results();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd);
		{avs_address, avs_writedata, avs_read, avs_write} <= {a, wd, ~we, we};
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		rd = avs_readdata;
		{avs_read, avs_write} <= 2'h0;
		@(posedge mclk);
	endtask
	task automatic rdchk(input string nm, input logic [3:0] a, input int e);
		bus(1'b0, a, 32'h0);
		chk(nm, 33'(e), 33'(rd));
	endtask
	task automatic model_chk();
		rdchk("status", fimc_pkg::OFF_STATUS, st);
		rdchk("state", fimc_pkg::OFF_STATE, stl | cs << 1 | (stl | cs) << 2);
		chk("irq", 33'((st & mk) != 0), 33'(irq));
	endtask
	task automatic wreg(input logic [3:0] a, input int v);
		if (a == fimc_pkg::OFF_MASK) mk = v;
		else st &= ~v;
		bus(1'b1, a, 32'(v));
		model_chk();
	endtask
	task automatic setc(input int f, input int m, input int r);
		{fx, me, rpt} = {f, m, r};
		bus(1'b1, fimc_pkg::OFF_CTRL, 32'(f | m << 1 | r << 2));
		rdchk("ctrl", fimc_pkg::OFF_CTRL, f | m << 1 | r << 2);
	endtask
	task automatic ctl();
		u_far.pulse();
		st |= 32'h8;
		stl = rpt != 0 ? 0 : stl;
		repeat (2) @(posedge mclk);
		chk("stall", 33'(stl), 33'(stall));
	endtask
	task automatic xfer(input logic f, input logic c = 1'b0);
		logic [31:0] d;
		int          b;
		d = $urandom;
		b = stl | cs;
		if (c) begin
			fork
				u_far.send(f, d[7], d);
				u_far.pulse();
			join
		end else begin
			u_far.send(f, d[7], d);
		end
		@(posedge mclk);
		chk("use_valid", 33'(!f && b == 0), 33'(use_valid));
		if (!f && b == 0) chk("use", {d[7], d}, {use_instr, use_data});
		else chk("use_data", 33'h0, 33'(use_data));
		chk("mchk", 33'(f && cs == 0 && fx && me), 33'(machine_check));
		if (f) st |= 32'h1;
		if (f && fx == 0 && stl == 0) st |= 32'h10;
		if (f && fx != 0 && cs == 0) st |= me != 0 ? 32'h2 : 32'h4;
		if (c) st |= 32'h8;
		if (f && fx == 0) stl = 1;
		else if (c && rpt != 0) stl = 0;
		if (f && fx != 0 && me == 0) cs = 1;
		@(posedge mclk);
		chk("stall", 33'(stl), 33'(stall));
		chk("checkstop", 33'(cs), 33'(checkstop));
	endtask
	task automatic reset_all();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (12) @(posedge mclk);
		chk("waitrequest", 33'h1, 33'(avs_waitrequest));
		rst <= 1'b0;
		{fx, me, rpt, st, mk, stl, cs} = '0;
		rdchk("ctrl", fimc_pkg::OFF_CTRL, 0);
		rdchk("mask", fimc_pkg::OFF_MASK, 0);
		rdchk("unmapped", 4'h1, 0);
		model_chk();
	endtask
	initial begin
		repeat (6000) @(posedge mclk);
		bad_count++;
		results();
	end
	initial begin
		{mclk, rst, avs_read, avs_write, avs_address, avs_writedata} = {2'h1, 38'h0};
		be = 4'hf;
		rd = $urandom(53);
		reset_all();
		for (int k = 0; k < 4; k++) xfer(1'b0);
		setc(0, 0, 1);
		xfer(1'b1);
		xfer(1'b0);
		model_chk();
		ctl();
		xfer(1'b0);
		xfer(1'b1, 1'b1);
		ctl();
		setc(1, 1, 0);
		xfer(1'b1);
		setc(1, 1, 1);
		ctl();
		model_chk();
		wreg(fimc_pkg::OFF_STATUS, 32'h1f);
		ctl();
		xfer(1'b1);
		xfer(1'b1, 1'b1);
		wreg(fimc_pkg::OFF_MASK, 32'h2);
		be <= 4'he;
		bus(1'b1, fimc_pkg::OFF_MASK, 32'h1f);
		be <= 4'hf;
		rdchk("mask", fimc_pkg::OFF_MASK, mk);
		wreg(fimc_pkg::OFF_MASK, 32'h0);
		wreg(fimc_pkg::OFF_STATUS, 32'h1f);
		wreg(fimc_pkg::OFF_MASK, 32'h1f);
		setc(1, 0, 0);
		xfer(1'b1);
		xfer(1'b0);
		model_chk();
		reset_all();
		results();
	end
endmodule // testbench
`default_nettype wire
